// *** slgc_defines.svh ***
// Purpose: Offsets, field positions, codes and frame counts of the pin block.
// Assumes: Included by bare name in the receiver, the pin block and the bench; the monitor writes its figures as literals.
// Notes: Definitions only.
`ifndef SLGC_DEFINES_SVH
`define SLGC_DEFINES_SVH

`define SLGC_OFS_LINK0_CFG 8'h0d
`define SLGC_OFS_LINK12_CFG 8'h0e
`define SLGC_OFS_LINK3_CFG 8'h0f
`define SLGC_OFS_REG56_CFG 8'h10
`define SLGC_OFS_REG78_CFG 8'h11
`define SLGC_OFS_IN_LOW 8'h1c
`define SLGC_OFS_IN_HIGH 8'h1d

`define SLGC_CFG_RESET 8'h00
`define SLGC_LO_NIB 3:0
`define SLGC_HI_NIB 7:4
`define SLGC_IN_REG8_BIT 0

`define SLGC_CODE_DRIVE_LOW 4'h1
`define SLGC_CODE_INPUT 4'h3
`define SLGC_CODE_BACK 4'h5
`define SLGC_CODE_DRIVE_HIGH 4'h9

`define SLGC_HDR_BITS 2'd3
`define SLGC_BCM_NORMAL 3'b000
`define SLGC_BCM_FAST4 3'b011
`define SLGC_BCM_FAST2 3'b010
`define SLGC_BCM_FAST1 3'b001
`define SLGC_SPF_NORMAL 4'd1
`define SLGC_SPF_FAST4 4'd6
`define SLGC_SPF_FAST2 4'd10
`define SLGC_SPF_FAST1 4'd15
`define SLGC_WID_FOUR 3'd4
`define SLGC_WID_TWO 3'd2
`define SLGC_WID_ONE 3'd1
`define SLGC_MASK_FOUR 4'hf
`define SLGC_MASK_TWO 4'h3
`define SLGC_MASK_ONE 4'h1

`endif

// *** slgc_pkg.sv ***
// Purpose: Types of the pin block.
// Assumes: Nothing is imported; users write slgc_pkg::name.
// Notes: State of each module is one packed struct.
package slgc_pkg;

    typedef enum logic [1:0] {
        SLGC_RX_IDLE = 2'b00,
        SLGC_RX_HDR = 2'b01,
        SLGC_RX_DATA = 2'b10,
        SLGC_RX_DONE = 2'b11
    } slgc_rx_state_type;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic clk_prev;
        slgc_rx_state_type state;
        logic [2:0] mode;
        logic [1:0] hdr_cnt;
        logic [2:0] bit_cnt;
        logic [3:0] smp_cnt;
        logic [3:0] shift;
        logic stb;
        logic [3:0] val;
        logic [3:0] mask;
    } slgc_rx_type;

    typedef struct packed {
        logic [7:0] cfg0d;
        logic [7:0] cfg0e;
        logic [7:0] cfg0f;
        logic [7:0] cfg10;
        logic [7:0] cfg11;
        logic [3:0] link_s1;
        logic [3:0] link_s2;
        logic [3:0] reg_s1;
        logic [3:0] reg_s2;
        logic [3:0] bc_val;
        logic [3:0] link_out;
        logic [3:0] link_oe_n;
        logic [3:0] reg_out;
        logic [3:0] reg_oe_n;
        logic [3:0] audio;
        logic [3:0] fc_val;
        logic [3:0] fc_en;
        logic [7:0] loc_rdata;
        logic [7:0] rem_rdata;
        logic loc_rvalid;
        logic rem_rvalid;
    } slgc_state_type;

endpackage : slgc_pkg

// *** slgc_bc_rx.sv ***
// Purpose: Receives back-channel frames and hands out pin samples.
// Assumes: Link clock, data and frame come from outside and are synchronised here.
// Notes: Frame is three mode bits, MSB first, then samples, first bit lands highest.
`timescale 1ns/10ps
`default_nettype none
`include "slgc_defines.svh"

module slgc_bc_rx (
    input wire logic clk,
    input wire logic rst,
    input wire logic bc_clk_pin,
    input wire logic bc_data_pin,
    input wire logic bc_frame_pin,
    output logic sample_stb,
    output logic [3:0] sample_val,
    output logic [3:0] sample_mask
);

    slgc_pkg::slgc_rx_type r_reg;
    slgc_pkg::slgc_rx_type r_next;

    always_comb begin
        logic rise;
        logic frame;
        logic data;
        logic [2:0] width;
        logic [3:0] spf;
        logic [3:0] mask;
        logic [3:0] sh;
        rise = r_reg.sync2[2] & ~r_reg.clk_prev;
        data = r_reg.sync2[1];
        frame = r_reg.sync2[0];
        width = `SLGC_WID_FOUR;
        spf = 4'h0;
        mask = 4'h0;
        sh = {r_reg.shift[2:0], data};
        r_next = r_reg;
        r_next.sync1 = {bc_clk_pin, bc_data_pin, bc_frame_pin};
        r_next.sync2 = r_reg.sync1;
        r_next.clk_prev = r_reg.sync2[2];
        r_next.stb = 1'b0;
        unique case (r_reg.mode)
            `SLGC_BCM_NORMAL: begin // [RULE6]
                width = `SLGC_WID_FOUR;
                spf = `SLGC_SPF_NORMAL;
                mask = `SLGC_MASK_FOUR;
            end
            `SLGC_BCM_FAST4: begin // [RULE6]
                width = `SLGC_WID_FOUR;
                spf = `SLGC_SPF_FAST4;
                mask = `SLGC_MASK_FOUR;
            end
            `SLGC_BCM_FAST2: begin // [RULE6]
                width = `SLGC_WID_TWO;
                spf = `SLGC_SPF_FAST2;
                mask = `SLGC_MASK_TWO;
            end
            `SLGC_BCM_FAST1: begin // [RULE6]
                width = `SLGC_WID_ONE;
                spf = `SLGC_SPF_FAST1;
                mask = `SLGC_MASK_ONE;
            end
            default: ;
        endcase
        unique case (r_reg.state)
            slgc_pkg::SLGC_RX_IDLE: begin
                r_next.hdr_cnt = 2'd0;
                if (frame) begin
                    r_next.state = slgc_pkg::SLGC_RX_HDR;
                end
            end
            slgc_pkg::SLGC_RX_HDR: begin
                if (!frame) begin
                    r_next.state = slgc_pkg::SLGC_RX_IDLE;
                end else if (rise) begin
                    r_next.mode = {r_reg.mode[1:0], data}; // [RULE7]
                    r_next.hdr_cnt = r_reg.hdr_cnt + 2'd1;
                    if (r_reg.hdr_cnt == `SLGC_HDR_BITS - 2'd1) begin
                        r_next.state = slgc_pkg::SLGC_RX_DATA;
                        r_next.bit_cnt = 3'd0;
                        r_next.smp_cnt = 4'd0;
                        r_next.shift = 4'h0;
                    end
                end
            end
            slgc_pkg::SLGC_RX_DATA: begin
                if (!frame) begin
                    r_next.state = slgc_pkg::SLGC_RX_IDLE;
                end else if (spf == 4'h0) begin
                    r_next.state = slgc_pkg::SLGC_RX_DONE;
                end else if (rise) begin
                    r_next.shift = sh;
                    if (r_reg.bit_cnt == width - 3'd1) begin
                        r_next.stb = 1'b1;
                        r_next.val = sh & mask;
                        r_next.mask = mask;
                        r_next.bit_cnt = 3'd0;
                        r_next.shift = 4'h0;
                        r_next.smp_cnt = r_reg.smp_cnt + 4'd1;
                        if (r_reg.smp_cnt == spf - 4'd1) begin
                            r_next.state = slgc_pkg::SLGC_RX_DONE;
                        end
                    end else begin
                        r_next.bit_cnt = r_reg.bit_cnt + 3'd1;
                    end
                end
            end
            slgc_pkg::SLGC_RX_DONE: begin
                if (!frame) begin
                    r_next.state = slgc_pkg::SLGC_RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign sample_stb = r_reg.stb;
    assign sample_val = r_reg.val;
    assign sample_mask = r_reg.mask;

endmodule : slgc_bc_rx
`default_nettype wire

// *** slgc_gpio.sv ***
// Purpose: Link pins and register-only pins of the serializer with their registers.
// Assumes: Local and remote register ports share one register file.
// Notes: All outputs come from flip-flops.
//
// Notes on behaviour
// [RULE1] Each link pin: forward or back channel.
// [RULE2] Pin 0 field 0x0D[3:0]: 3 forward, 5 back.
// [RULE3] Pin 1 field 0x0E[3:0]: 3 forward, 5 back.
// [RULE4] Pin 2 field 0x0E[7:4]: 3 forward, 5 back.
// [RULE5] Pin 3 field 0x0F[3:0]: same codes.
// [RULE6] Remote mode code sets pins and samples.
// [RULE7] Far end chooses mode and rate.
// [RULE8] Far end rate bits pick 5/10/20 Mbps.
// [RULE9] Register-only pins move through local bits only.
// [RULE10] Register-pin mode overrides the shared audio input.
// [RULE11] Local and remote ports reach the pins.
// [RULE12] Register-only pins never go over link.
// [RULE13] Pin 8: 0x11[7:4], 1/9/3, reads 0x1D[0].
// [RULE14] Pin 7: 0x11[3:0], 1/9/3, reads 0x1C[7].
// [RULE15] Pin 6: 0x10[7:4], 1/9/3, reads 0x1C[6].
// [RULE16] Pin 5: 0x10[3:0], 1/9/3, reads 0x1C[5].
// [RULE17] Link pins 3,2 local 1/9/3, read 0x1C[3:2].
// [RULE18] Link pins 1,0 local 1/9/3, read 0x1C[1:0].
`timescale 1ns/10ps
`default_nettype none
`include "slgc_defines.svh"

module slgc_gpio (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] loc_addr,
    input wire logic [7:0] loc_wdata,
    input wire logic loc_wr,
    input wire logic loc_rd,
    output logic [7:0] loc_rdata,
    output logic loc_rvalid,
    input wire logic [7:0] rem_addr,
    input wire logic [7:0] rem_wdata,
    input wire logic rem_wr,
    input wire logic rem_rd,
    output logic [7:0] rem_rdata,
    output logic rem_rvalid,
    input wire logic [3:0] link_pin_in,
    output logic [3:0] link_pin_out,
    output logic [3:0] link_pin_oe_n,
    input wire logic [3:0] reg_pin_in,
    output logic [3:0] reg_pin_out,
    output logic [3:0] reg_pin_oe_n,
    output logic [3:0] audio_in_out,
    output logic [3:0] fc_pin_val,
    output logic [3:0] fc_pin_en,
    input wire logic bc_clk_pin,
    input wire logic bc_data_pin,
    input wire logic bc_frame_pin
);

    ////////////////////////////////////////////////////////////////////////
    // State and back-channel receiver.

    slgc_pkg::slgc_state_type r_reg;
    slgc_pkg::slgc_state_type r_next;
    logic bc_stb;
    logic [3:0] bc_val;
    logic [3:0] bc_mask;
    logic [3:0][3:0] link_cfg;
    logic [3:0][3:0] reg_cfg;
    logic [7:0] in_low;
    logic [7:0] in_high;

    slgc_bc_rx u_bc_rx (
        .clk(clk),
        .rst(rst),
        .bc_clk_pin(bc_clk_pin),
        .bc_data_pin(bc_data_pin),
        .bc_frame_pin(bc_frame_pin),
        .sample_stb(bc_stb),
        .sample_val(bc_val),
        .sample_mask(bc_mask)
    );

    ////////////////////////////////////////////////////////////////////////
    // Config fields per pin and input status.

    assign link_cfg[0] = r_reg.cfg0d[`SLGC_LO_NIB]; // [RULE2]
    assign link_cfg[1] = r_reg.cfg0e[`SLGC_LO_NIB]; // [RULE3]
    assign link_cfg[2] = r_reg.cfg0e[`SLGC_HI_NIB]; // [RULE4]
    assign link_cfg[3] = r_reg.cfg0f[`SLGC_LO_NIB]; // [RULE5]
    assign reg_cfg[0] = r_reg.cfg10[`SLGC_LO_NIB]; // [RULE16]
    assign reg_cfg[1] = r_reg.cfg10[`SLGC_HI_NIB]; // [RULE15]
    assign reg_cfg[2] = r_reg.cfg11[`SLGC_LO_NIB]; // [RULE14]
    assign reg_cfg[3] = r_reg.cfg11[`SLGC_HI_NIB]; // [RULE13]

    always_comb begin
        in_low = 8'h00;
        in_high = 8'h00;
        for (int i = 0; i < 4; i++) begin
            in_low[i] = r_reg.link_s2[i] & (link_cfg[i] == `SLGC_CODE_INPUT); // [RULE17] [RULE18]
        end
        for (int i = 0; i < 3; i++) begin
            in_low[5 + i] = r_reg.reg_s2[i] & (reg_cfg[i] == `SLGC_CODE_INPUT); // [RULE14] [RULE15] [RULE16]
        end
        in_high[`SLGC_IN_REG8_BIT] = r_reg.reg_s2[3] & (reg_cfg[3] == `SLGC_CODE_INPUT); // [RULE13]
    end

    ////////////////////////////////////////////////////////////////////////
    // Register access helpers.

    function automatic slgc_pkg::slgc_state_type wr_reg(
        input slgc_pkg::slgc_state_type s,
        input logic [7:0] a,
        input logic [7:0] d
    );
        unique case (a)
            `SLGC_OFS_LINK0_CFG: s.cfg0d = d;
            `SLGC_OFS_LINK12_CFG: s.cfg0e = d;
            `SLGC_OFS_LINK3_CFG: s.cfg0f = d;
            `SLGC_OFS_REG56_CFG: s.cfg10 = d;
            `SLGC_OFS_REG78_CFG: s.cfg11 = d;
            default: ;
        endcase
        return s;
    endfunction : wr_reg

    function automatic logic [7:0] rd_reg(
        input slgc_pkg::slgc_state_type s,
        input logic [7:0] a,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [7:0] v;
        unique case (a)
            `SLGC_OFS_LINK0_CFG: v = s.cfg0d;
            `SLGC_OFS_LINK12_CFG: v = s.cfg0e;
            `SLGC_OFS_LINK3_CFG: v = s.cfg0f;
            `SLGC_OFS_REG56_CFG: v = s.cfg10;
            `SLGC_OFS_REG78_CFG: v = s.cfg11;
            `SLGC_OFS_IN_LOW: v = lo;
            `SLGC_OFS_IN_HIGH: v = hi;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : rd_reg

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        r_next = r_reg;
        r_next.link_s1 = link_pin_in;
        r_next.link_s2 = r_reg.link_s1;
        r_next.reg_s1 = reg_pin_in;
        r_next.reg_s2 = r_reg.reg_s1;

        // Both ports write; the local one wins on the same offset.
        if (rem_wr) begin
            r_next = wr_reg(r_next, rem_addr, rem_wdata); // [RULE11]
        end
        if (loc_wr) begin
            r_next = wr_reg(r_next, loc_addr, loc_wdata); // [RULE11]
        end
        r_next.loc_rvalid = loc_rd;
        r_next.rem_rvalid = rem_rd;
        if (loc_rd) begin
            r_next.loc_rdata = rd_reg(r_reg, loc_addr, in_low, in_high); // [RULE11]
        end
        if (rem_rd) begin
            r_next.rem_rdata = rd_reg(r_reg, rem_addr, in_low, in_high); // [RULE11]
        end

        if (bc_stb) begin
            r_next.bc_val = (r_reg.bc_val & ~bc_mask) | (bc_val & bc_mask); // [RULE6] [RULE7]
        end

        for (int i = 0; i < 4; i++) begin
            r_next.link_out[i] = 1'b0;
            r_next.link_oe_n[i] = 1'b1;
            r_next.fc_en[i] = 1'b0;
            unique case (link_cfg[i])
                `SLGC_CODE_DRIVE_LOW: begin // [RULE17] [RULE18]
                    r_next.link_oe_n[i] = 1'b0;
                end
                `SLGC_CODE_DRIVE_HIGH: begin
                    r_next.link_out[i] = 1'b1;
                    r_next.link_oe_n[i] = 1'b0;
                end
                `SLGC_CODE_INPUT: begin // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
                    r_next.fc_en[i] = 1'b1;
                end
                `SLGC_CODE_BACK: begin // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
                    r_next.link_out[i] = r_reg.bc_val[i];
                    r_next.link_oe_n[i] = 1'b0;
                end
                default: ;
            endcase
            r_next.fc_val[i] = r_reg.link_s2[i] & r_next.fc_en[i]; // [RULE1]
        end

        for (int i = 0; i < 4; i++) begin
            r_next.reg_out[i] = 1'b0;
            r_next.reg_oe_n[i] = 1'b1;
            r_next.audio[i] = r_reg.reg_s2[i];
            unique case (reg_cfg[i])
                `SLGC_CODE_DRIVE_LOW: begin // [RULE9] [RULE13] [RULE14] [RULE15] [RULE16]
                    r_next.reg_oe_n[i] = 1'b0;
                    r_next.audio[i] = 1'b0; // [RULE10]
                end
                `SLGC_CODE_DRIVE_HIGH: begin
                    r_next.reg_out[i] = 1'b1;
                    r_next.reg_oe_n[i] = 1'b0;
                    r_next.audio[i] = 1'b0; // [RULE10]
                end
                `SLGC_CODE_INPUT: begin // [RULE9] [RULE12]
                    r_next.audio[i] = 1'b0; // [RULE10]
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.cfg0d <= `SLGC_CFG_RESET;
            r_reg.cfg0e <= `SLGC_CFG_RESET;
            r_reg.cfg0f <= `SLGC_CFG_RESET;
            r_reg.cfg10 <= `SLGC_CFG_RESET;
            r_reg.cfg11 <= `SLGC_CFG_RESET;
            r_reg.link_oe_n <= 4'hf;
            r_reg.reg_oe_n <= 4'hf;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign loc_rdata = r_reg.loc_rdata;
    assign loc_rvalid = r_reg.loc_rvalid;
    assign rem_rdata = r_reg.rem_rdata;
    assign rem_rvalid = r_reg.rem_rvalid;
    assign link_pin_out = r_reg.link_out;
    assign link_pin_oe_n = r_reg.link_oe_n;
    assign reg_pin_out = r_reg.reg_out;
    assign reg_pin_oe_n = r_reg.reg_oe_n;
    assign audio_in_out = r_reg.audio;
    assign fc_pin_val = r_reg.fc_val; // [RULE12]
    assign fc_pin_en = r_reg.fc_en;

endmodule : slgc_gpio
`default_nettype wire

// *** slgc_gpio_monitor.sv ***
// Purpose: Port checker of the pin block.
// Assumes: Bound to slgc_gpio from the bench.
// Notes: One clock domain; reset disables every property.
`timescale 1ns/10ps
`default_nettype none
module slgc_gpio_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] loc_addr,
    input wire logic [7:0] loc_wdata,
    input wire logic loc_wr,
    input wire logic loc_rd,
    input wire logic [7:0] loc_rdata,
    input wire logic loc_rvalid,
    input wire logic rem_wr,
    input wire logic rem_rd,
    input wire logic rem_rvalid,
    input wire logic [3:0] link_pin_out,
    input wire logic [3:0] link_pin_oe_n,
    input wire logic [3:0] reg_pin_out,
    input wire logic [3:0] reg_pin_oe_n,
    input wire logic [3:0] fc_pin_val,
    input wire logic [3:0] fc_pin_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    property p_loc_rvalid;
        loc_rd |=> loc_rvalid ##1 (loc_rvalid == $past(loc_rd));
    endproperty
    a_loc_rvalid: assert property (p_loc_rvalid) else $error("local read answer wrong");
    property p_rem_rvalid;
        rem_rd |=> rem_rvalid;
    endproperty
    a_rem_rvalid: assert property (p_rem_rvalid) else $error("remote read answer late");
    property p_unmapped;
        loc_rd && !(loc_addr inside {8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h1c, 8'h1d})
            |=> loc_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_status_high;
        loc_rd && loc_addr == 8'h1d |=> loc_rdata[7:1] == 7'h00;
    endproperty
    a_status_high: assert property (p_status_high) else $error("pin 8 status spare bits");
    property p_fc_gate;
        (fc_pin_val & ~fc_pin_en) == 4'h0;
    endproperty
    a_fc_gate: assert property (p_fc_gate) else $error("forward value without enable");
    property p_fc_not_driven;
        (fc_pin_en & ~link_pin_oe_n) == 4'h0;
    endproperty
    a_fc_not_driven: assert property (p_fc_not_driven) else $error("forward pin driven");
    property p_reg_drive_high;
        loc_wr && loc_addr == 8'h10 && loc_wdata[3:0] == 4'h9
            |=> ##1 reg_pin_out[0] && !reg_pin_oe_n[0];
    endproperty
    a_reg_drive_high: assert property (p_reg_drive_high) else $error("pin 5 not high");
    property p_link_drive_low;
        loc_wr && loc_addr == 8'h0d && loc_wdata[3:0] == 4'h1
            |=> ##1 !link_pin_out[0] && !link_pin_oe_n[0];
    endproperty
    a_link_drive_low: assert property (p_link_drive_low) else $error("pin 0 not low");
    property p_readback;
        loc_wr && loc_addr == 8'h11 && !rem_wr ##1 loc_rd && loc_addr == 8'h11 && !loc_wr
            && !rem_wr |=> loc_rdata == $past(loc_wdata, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("config read back wrong");
endmodule : slgc_gpio_monitor
`default_nettype wire

// *** slgc_far_end.sv ***
// Purpose: Far-end model that sends back-channel frames.
// Assumes: Its link clock stands low outside frames.
// Notes: Idle data shows the inverse of its last bit.
`timescale 1ns/10ps
`default_nettype none
module slgc_far_end (
    output logic bc_clk_pin,
    output logic bc_data_pin,
    output logic bc_frame_pin
);
    initial {bc_clk_pin, bc_data_pin, bc_frame_pin} = 3'b000;
    ////////////////////////////////////////////////////////////
    task automatic put_bit(input logic b);
        bc_data_pin = b;
        #80 bc_clk_pin = 1'b1;
        #80 bc_clk_pin = 1'b0;
    endtask : put_bit
    // Samples before the last one are its inverse.
    task automatic send_frame(input logic [2:0] mode, input logic [3:0] last, input int nsmp,
                              input int wid);
        logic [3:0] smp;
        bc_frame_pin = 1'b1;
        #80;
        for (int i = 2; i >= 0; i--) begin
            put_bit(mode[i]);
        end
        for (int s = 0; s < nsmp; s++) begin
            smp = (s == nsmp - 1) ? last : ~last;
            for (int b = wid - 1; b >= 0; b--) begin
                put_bit(smp[b]);
            end
        end
        #80 bc_frame_pin = 1'b0;
        bc_data_pin = ~bc_data_pin;
        #80;
    endtask : send_frame
endmodule : slgc_far_end
`default_nettype wire

// *** slgc_gpio_tb.sv ***
// Purpose: Self-checking bench of the pin block.
// Assumes: Far-end model sends back-channel frames.
// Notes: Pin wires resolve from the design's enables.
`timescale 1ns/10ps
`default_nettype none
`include "slgc_defines.svh"
bind slgc_gpio slgc_gpio_monitor mon (.*);
module slgc_gpio_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] loc_addr = 8'h00, loc_wdata = 8'h00, rem_addr = 8'h00, rem_wdata = 8'h00;
    logic loc_wr = 1'b0, loc_rd = 1'b0, rem_wr = 1'b0, rem_rd = 1'b0;
    logic [7:0] loc_rdata, rem_rdata;
    logic loc_rvalid, rem_rvalid, bc_clk_pin, bc_data_pin, bc_frame_pin;
    logic [3:0] link_lvl = 4'h0, reg_lvl = 4'h0;
    logic [3:0] link_pin_in, link_pin_out, link_pin_oe_n, reg_pin_in, reg_pin_out, reg_pin_oe_n;
    logic [3:0] audio_in_out, fc_pin_val, fc_pin_en;
    int n_errors = 0, n_compared = 0;
    always #4 clk = ~clk;
    assign link_pin_in = (link_pin_oe_n & link_lvl) | (~link_pin_oe_n & link_pin_out);
    assign reg_pin_in = (reg_pin_oe_n & reg_lvl) | (~reg_pin_oe_n & reg_pin_out);
    slgc_gpio dut (.clk(clk), .rst(rst), .loc_addr(loc_addr), .loc_wdata(loc_wdata),
        .loc_wr(loc_wr), .loc_rd(loc_rd), .loc_rdata(loc_rdata), .loc_rvalid(loc_rvalid),
        .rem_addr(rem_addr), .rem_wdata(rem_wdata), .rem_wr(rem_wr), .rem_rd(rem_rd),
        .rem_rdata(rem_rdata), .rem_rvalid(rem_rvalid), .link_pin_in(link_pin_in),
        .link_pin_out(link_pin_out), .link_pin_oe_n(link_pin_oe_n), .reg_pin_in(reg_pin_in),
        .reg_pin_out(reg_pin_out), .reg_pin_oe_n(reg_pin_oe_n), .audio_in_out(audio_in_out),
        .fc_pin_val(fc_pin_val), .fc_pin_en(fc_pin_en), .bc_clk_pin(bc_clk_pin),
        .bc_data_pin(bc_data_pin), .bc_frame_pin(bc_frame_pin));
    slgc_far_end far (.bc_clk_pin(bc_clk_pin), .bc_data_pin(bc_data_pin),
        .bc_frame_pin(bc_frame_pin));
    ////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic rem, input logic [7:0] a, input logic [7:0] d);
        if (rem) begin
            rem_addr = a;
            rem_wdata = d;
            rem_wr = 1'b1;
        end else begin
            loc_addr = a;
            loc_wdata = d;
            loc_wr = 1'b1;
        end
        step(1);
        if (rem) begin
            rem_wr = 1'b0;
        end else begin
            loc_wr = 1'b0;
        end
    endtask : wr
    task automatic rdchk(input logic rem, input logic [7:0] a, input logic [7:0] exp);
        int n;
        if (rem) begin
            rem_addr = a;
            rem_rd = 1'b1;
        end else begin
            loc_addr = a;
            loc_rd = 1'b1;
        end
        step(1);
        loc_rd = 1'b0;
        rem_rd = 1'b0;
        n = 0;
        while ((rem ? rem_rvalid : loc_rvalid) !== 1'b1 && n < 4) begin
            step(1);
            n++;
        end
        if (n == 4) begin
            n_errors++;
            summarize();
        end
        chk(rem ? rem_rdata : loc_rdata, exp);
        step(1);
    endtask : rdchk
    ////////////////////////////////////////////////////////////
    task automatic scen_reset;
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        step(1);
        rdchk(0, `SLGC_OFS_LINK0_CFG, `SLGC_CFG_RESET);
        rdchk(0, `SLGC_OFS_LINK12_CFG, `SLGC_CFG_RESET);
        rdchk(1, `SLGC_OFS_LINK3_CFG, `SLGC_CFG_RESET);
        rdchk(0, `SLGC_OFS_REG56_CFG, `SLGC_CFG_RESET);
        rdchk(1, `SLGC_OFS_REG78_CFG, `SLGC_CFG_RESET);
        chk({link_pin_oe_n, reg_pin_oe_n}, 8'hff);
    endtask : scen_reset
    task automatic scen_link_local;
        logic [7:0] a [4] = '{`SLGC_OFS_LINK0_CFG, `SLGC_OFS_LINK12_CFG, `SLGC_OFS_LINK12_CFG,
            `SLGC_OFS_LINK3_CFG};
        int sh [4] = '{0, 0, 4, 0};
        for (int i = 0; i < 4; i++) begin
            wr(0, a[i], 8'(`SLGC_CODE_DRIVE_HIGH) << sh[i]);
            step(1);
            chk(8'({link_pin_out[i], link_pin_oe_n[i]}), 8'h02);
            wr(0, a[i], 8'(`SLGC_CODE_DRIVE_LOW) << sh[i]);
            step(1);
            chk(8'({link_pin_out[i], link_pin_oe_n[i]}), 8'h00);
            link_lvl[i] = 1'b1;
            wr(0, a[i], 8'(`SLGC_CODE_INPUT) << sh[i]);
            step(4);
            chk({fc_pin_en, fc_pin_val}, 8'h11 << i);
            rdchk(0, `SLGC_OFS_IN_LOW, 8'h01 << i);
            link_lvl[i] = 1'b0;
            step(4);
            chk({fc_pin_en, fc_pin_val}, 8'h10 << i);
            wr(0, a[i], 8'(`SLGC_CODE_BACK) << sh[i]);
            step(1);
            chk(8'({fc_pin_en, link_pin_oe_n[i]}), 8'h00);
            wr(0, a[i], 8'h00);
            step(1);
        end
    endtask : scen_link_local
    task automatic scen_reg_local;
        logic [7:0] a [4] = '{`SLGC_OFS_REG56_CFG, `SLGC_OFS_REG56_CFG, `SLGC_OFS_REG78_CFG,
            `SLGC_OFS_REG78_CFG};
        logic [7:0] sa [4] = '{`SLGC_OFS_IN_LOW, `SLGC_OFS_IN_LOW, `SLGC_OFS_IN_LOW,
            `SLGC_OFS_IN_HIGH};
        int sh [4] = '{0, 4, 0, 4};
        int sb [4] = '{5, 6, 7, 0};
        for (int i = 0; i < 4; i++) begin
            reg_lvl[i] = 1'b1;
            step(4);
            chk(8'(audio_in_out), 8'h01 << i);
            wr(0, a[i], 8'(`SLGC_CODE_DRIVE_HIGH) << sh[i]);
            step(1);
            chk(8'({reg_pin_out[i], reg_pin_oe_n[i]}), 8'h02);
            chk({fc_pin_en, fc_pin_val}, 8'h00);
            wr(0, a[i], 8'(`SLGC_CODE_DRIVE_LOW) << sh[i]);
            step(1);
            chk(8'({reg_pin_out[i], reg_pin_oe_n[i]}), 8'h00);
            wr(0, a[i], 8'(`SLGC_CODE_INPUT) << sh[i]);
            step(4);
            chk(8'({audio_in_out[i], reg_pin_oe_n[i]}), 8'h01);
            rdchk(0, sa[i], 8'h01 << sb[i]);
            wr(0, a[i], 8'h00);
            reg_lvl[i] = 1'b0;
        end
    endtask : scen_reg_local
    task automatic scen_remote;
        wr(1, `SLGC_OFS_LINK3_CFG, 8'ha3);
        rdchk(0, `SLGC_OFS_LINK3_CFG, 8'ha3);
        wr(0, `SLGC_OFS_REG78_CFG, 8'h39);
        rdchk(0, `SLGC_OFS_REG78_CFG, 8'h39);
        reg_lvl[3] = 1'b1;
        wr(0, `SLGC_OFS_IN_LOW, 8'hff);
        step(4);
        rdchk(1, `SLGC_OFS_IN_LOW, 8'h00);
        rdchk(1, `SLGC_OFS_IN_HIGH, 8'h01);
        rdchk(1, 8'h20, 8'h00);
        loc_addr = `SLGC_OFS_REG56_CFG;
        rem_addr = `SLGC_OFS_REG56_CFG;
        loc_wdata = 8'h11;
        rem_wdata = 8'h99;
        loc_wr = 1'b1;
        rem_wr = 1'b1;
        step(1);
        loc_wr = 1'b0;
        rem_wr = 1'b0;
        rdchk(1, `SLGC_OFS_REG56_CFG, 8'h11);
        reg_lvl[3] = 1'b0;
    endtask : scen_remote
    task automatic scen_back_channel;
        wr(0, `SLGC_OFS_LINK0_CFG, 8'h05);
        wr(1, `SLGC_OFS_LINK12_CFG, 8'h55);
        wr(0, `SLGC_OFS_LINK3_CFG, 8'h05);
        far.send_frame(`SLGC_BCM_NORMAL, 4'hb, 1, 4);
        step(12);
        chk({link_pin_oe_n, link_pin_out}, 8'h0b);
        far.send_frame(`SLGC_BCM_FAST4, 4'h6, 6, 4);
        step(12);
        chk({link_pin_oe_n, link_pin_out}, 8'h06);
        far.send_frame(`SLGC_BCM_FAST2, 4'h1, 10, 2);
        step(12);
        chk({link_pin_oe_n, link_pin_out}, 8'h05);
        far.send_frame(`SLGC_BCM_FAST1, 4'h0, 15, 1);
        step(12);
        chk({link_pin_oe_n, link_pin_out}, 8'h04);
        chk({reg_pin_oe_n, fc_pin_en}, 8'hf0);
    endtask : scen_back_channel
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        step(1);
        scen_reset();
        scen_link_local();
        scen_reg_local();
        scen_remote();
        scen_reset();
        scen_back_channel();
        summarize();
    end
endmodule : slgc_gpio_tb
`default_nettype wire
